// [verilog/prs_pkg.sv]
package prs_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam int unsigned ADDR_W = 32;
  localparam logic [31:0] OFF_BANDGAP    = 32'h5000_0050;
  localparam logic [31:0] OFF_P0_RET     = 32'h5000_0070;
  localparam logic [31:0] OFF_P0_SET     = 32'h5000_0074;
  localparam logic [31:0] OFF_P0_CLR     = 32'h5000_0078;
  localparam logic [31:0] OFF_P1_RET     = 32'h5000_007C;
  localparam logic [31:0] OFF_P1_SET     = 32'h5000_0080;
  localparam logic [31:0] OFF_P1_CLR     = 32'h5000_0084;
  localparam logic [31:0] OFF_PIN_CFG    = 32'h5000_0098;
  localparam logic [31:0] OFF_HOLD_TIME  = 32'h5000_009C;
  localparam logic [31:0] OFF_RF_BIAS    = 32'h5000_00A4;
  localparam logic [31:0] OFF_CAUSE      = 32'h5000_00BC;
  localparam logic [31:0] OFF_DBG_RESET  = 32'h5000_00C4;
  localparam logic [31:0] OFF_IRQ_STAT   = 32'h5000_00D0;
  localparam logic [31:0] OFF_IRQ_EN     = 32'h5000_00D4;
  localparam logic [31:0] OFF_IRQ_CLR    = 32'h5000_00D8;

  // ==========================================================================
  // Reset values and field layout
  // ==========================================================================
  localparam logic [15:0] RET_RST        = 16'hFFFF;
  localparam logic [10:0] BANDGAP_RST    = 11'h000;
  localparam logic [7:0]  RF_BIAS_RST    = 8'h3A;
  localparam logic [5:0]  SEL_DISABLED   = 6'h3F;
  localparam logic [5:0]  SEL_PORT1_BASE = 6'h10;
  localparam logic [5:0]  SEL_RSVD_BASE  = 6'h20;
  localparam logic [6:0]  HOLD_RST       = 7'h18;
  localparam logic [5:0]  CAUSE_RST      = 6'h3F;
  localparam int unsigned POL_BIT        = 7;
  localparam int unsigned HOLD_UNIT      = 4096;

  localparam int unsigned F_POR  = 0;
  localparam int unsigned F_HW   = 1;
  localparam int unsigned F_SW   = 2;
  localparam int unsigned F_AWD  = 3;
  localparam int unsigned F_DBG  = 4;
  localparam int unsigned F_EWD  = 5;

  // Interrupt event bits
  localparam int unsigned IRQ_W       = 2;
  localparam int unsigned IRQ_PIN_POR = 0;
  localparam int unsigned IRQ_CAUSE   = 1;

  typedef struct packed {
    logic        polarity;
    logic        rsvd;
    logic [5:0]  select;
  } prs_pin_cfg_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } prs_bus_req_t;

  typedef struct packed {
    logic engine_wdog;
    logic debug_write;
    logic app_wdog;
    logic software;
    logic hardware;
    logic power_on;
  } prs_events_t;

  typedef enum logic [1:0] {
    HOLD_IDLE  = 2'b00,
    HOLD_COUNT = 2'b01,
    HOLD_FIRED = 2'b10
  } prs_hold_t;

endpackage

// [verilog/prs_reset_ctrl.sv]
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

// Operation
// - Pad controls freeze while retention bit is 0, pass when 1; reset all ones.
// - Set alias write forces marked retention bits to 1; alias reads zero.
// - Clear alias write forces marked retention bits to 0; alias reads zero.
// - Select codes 0x00-0x0F pick port 0 pins, 0x10-0x1F port 1; above reserved.
// - Select all ones (reset value) disables GPIO power-on reset.
// - Polarity bit 0 active low, 1 active high; GPIO source only.
// - Dedicated reset pad always active high.
// - Pin reset fires after hold field times 4096 fast RC periods active.
// - Status bit 5 sets on engine watchdog timeout and on power-on reset.
// - Status bit 4 sets on debug-port reset write and on power-on reset.
// - Status bit 3 sets on application watchdog timeout and power-on reset.
// - Status bit 2 sets on software reset.
// - Status bit 1 sets on hardware reset.
// - Status bit 0 sets on power-on reset; all six reset to 1.
// - Software reads then clears flags; cleared flags stay 0 until new events.
module prs_reset_ctrl
  import prs_pkg::*;
#(
  parameter int unsigned HOLD_UNIT_CYC = HOLD_UNIT  // Fast RC periods per hold step
)(
  input  wire logic        clock,             // System clock
  input  wire logic        sys_rst,           // Sync reset, active high
  input  wire logic [31:0] bus_addr,          // Register byte address
  input  wire logic [31:0] bus_wdata,         // Write data
  input  wire logic        bus_wr,            // Write strobe
  input  wire logic        bus_rd,            // Read strobe
  output logic      [31:0] bus_rdata,         // Read data, cycle after strobe
  input  wire logic        fast_rc_tick,      // One pulse per fast RC period
  input  wire logic [15:0] port0_pins,        // Port 0 pad inputs
  input  wire logic [15:0] port1_pins,        // Port 1 pad inputs
  input  wire logic        reset_pad,         // Dedicated reset pad
  input  wire logic        engine_wdog_evt,   // Protocol engine watchdog timeout
  input  wire logic        app_wdog_evt,      // Application watchdog timeout
  input  wire logic        sw_reset_evt,      // Software reset
  input  wire logic        por_evt,           // Power-on reset from supervisor
  input  wire logic [31:0] port0_ctrl_in,     // Port 0 pad controls, 2 bits per pad
  input  wire logic [31:0] port1_ctrl_in,     // Port 1 pad controls, 2 bits per pad
  output logic      [31:0] port0_ctrl_out,    // Port 0 retained controls
  output logic      [31:0] port1_ctrl_out,    // Port 1 retained controls
  output logic      [15:0] port0_retention_bits, // Port 0 retention enables
  output logic      [15:0] port1_retention_bits, // Port 1 retention enables
  output logic             pin_por_r,         // Pin power-on reset request pulse
  output logic             hw_reset_r,        // Reset pad active, registered
  output logic      [10:0] bandgap_trim_r,    // Bandgap trim field
  output logic      [7:0]  rf_bias_sel_r,     // RF bias reference select
  output logic             irq_r              // Level interrupt
);

  // Unit counter is only 16 bits wide
  if (HOLD_UNIT_CYC < 1 || HOLD_UNIT_CYC > 65536)
  begin : g_unit_check
    $error("HOLD_UNIT_CYC out of range");
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] hold_mask(input logic [15:0] en, input logic [31:0] cur,
                                            input logic [31:0] nxt);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 16; i++)
      if (en[i])
        res[2*i +: 2] = nxt[2*i +: 2];
    return res;
  endfunction

  function automatic logic [15:0] apply_alias(input logic [15:0] cur, input logic [15:0] set_m,
                                              input logic [15:0] clr_m);
    return (cur | set_m) & ~clr_m;
  endfunction

  prs_bus_req_t req;
  assign req = '{wr: bus_wr, rd: bus_rd, addr: bus_addr, wdata: bus_wdata};

  prs_pin_cfg_t pin_cfg_r;
  logic [6:0]   hold_time_r;
  logic [5:0]   cause_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;

  // ==========================================================================
  // Pad retention
  // ==========================================================================
  logic [15:0] p0_set, p0_clr, p1_set, p1_clr;
  assign p0_set = (req.wr && req.addr == OFF_P0_SET) ? req.wdata[15:0] : 16'h0000;
  assign p0_clr = (req.wr && req.addr == OFF_P0_CLR) ? req.wdata[15:0] : 16'h0000;
  assign p1_set = (req.wr && req.addr == OFF_P1_SET) ? req.wdata[15:0] : 16'h0000;
  assign p1_clr = (req.wr && req.addr == OFF_P1_CLR) ? req.wdata[15:0] : 16'h0000;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      port0_retention_bits <= RET_RST;
      port1_retention_bits <= RET_RST;
    end
    else
    begin
      if (req.wr && req.addr == OFF_P0_RET)
        port0_retention_bits <= req.wdata[15:0];
      else
        port0_retention_bits <= apply_alias(port0_retention_bits, p0_set, p0_clr);
      if (req.wr && req.addr == OFF_P1_RET)
        port1_retention_bits <= req.wdata[15:0];
      else
        port1_retention_bits <= apply_alias(port1_retention_bits, p1_set, p1_clr);
    end
  end

  // Controls follow one cycle late; frozen pads keep their last value
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      port0_ctrl_out <= port0_ctrl_in;
      port1_ctrl_out <= port1_ctrl_in;
    end
    else
    begin
      port0_ctrl_out <= hold_mask(port0_retention_bits, port0_ctrl_out, port0_ctrl_in);
      port1_ctrl_out <= hold_mask(port1_retention_bits, port1_ctrl_out, port1_ctrl_in);
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pin_cfg_r      <= '{polarity: 1'b0, rsvd: 1'b0, select: SEL_DISABLED};
      hold_time_r    <= HOLD_RST;
      bandgap_trim_r <= BANDGAP_RST;
      rf_bias_sel_r  <= RF_BIAS_RST;
      irq_en_r       <= '0;
    end
    else if (req.wr)
    begin
      if (req.addr == OFF_PIN_CFG)
        pin_cfg_r <= prs_pin_cfg_t'({req.wdata[7], 1'b0, req.wdata[5:0]});
      else if (req.addr == OFF_HOLD_TIME)
        hold_time_r <= req.wdata[6:0];
      else if (req.addr == OFF_BANDGAP)
        bandgap_trim_r <= req.wdata[10:0] & 11'h7DF;
      else if (req.addr == OFF_RF_BIAS)
        rf_bias_sel_r <= req.wdata[7:0];
      else if (req.addr == OFF_IRQ_EN)
        irq_en_r <= req.wdata[IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // Reset pin selection and hold timer
  // ==========================================================================
  logic [31:0] all_pins;
  logic        sel_level;
  logic        sel_valid;
  logic        pin_active;
  assign all_pins   = {port1_pins, port0_pins};
  assign sel_valid  = pin_cfg_r.select < SEL_RSVD_BASE;
  assign sel_level  = all_pins[pin_cfg_r.select[4:0]];
  assign pin_active = sel_valid && (sel_level == pin_cfg_r.polarity);

  prs_hold_t   hold_st_r;
  logic [15:0] unit_cnt_r;
  logic [6:0]  step_cnt_r;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hold_st_r  <= HOLD_IDLE;
      unit_cnt_r <= '0;
      step_cnt_r <= '0;
      pin_por_r  <= 1'b0;
    end
    else
    begin
      pin_por_r <= 1'b0;
      case (hold_st_r)
        HOLD_IDLE:
        begin
          unit_cnt_r <= '0;
          step_cnt_r <= '0;
          if (pin_active)
            hold_st_r <= HOLD_COUNT;
        end
        HOLD_COUNT:
        begin
          if (!pin_active)
          begin
            hold_st_r  <= HOLD_IDLE;
            unit_cnt_r <= '0;
            step_cnt_r <= '0;
          end
          else if (step_cnt_r >= hold_time_r)
          begin
            hold_st_r <= HOLD_FIRED;
            pin_por_r <= 1'b1;
          end
          else if (fast_rc_tick)
          begin
            if (unit_cnt_r == 16'(HOLD_UNIT_CYC - 1))
            begin
              unit_cnt_r <= '0;
              step_cnt_r <= step_cnt_r + 7'd1;
            end
            else
              unit_cnt_r <= unit_cnt_r + 16'd1;
          end
        end
        HOLD_FIRED:
        begin
          if (!pin_active)
            hold_st_r <= HOLD_IDLE;
        end
        default:
          hold_st_r <= HOLD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      hw_reset_r <= 1'b0;
    else
      hw_reset_r <= reset_pad;
  end

  // ==========================================================================
  // Reset cause flags
  // ==========================================================================
  prs_events_t ev;
  logic        any_por;
  logic [5:0]  ev_bits;
  assign any_por = por_evt | pin_por_r;
  assign ev = '{engine_wdog: engine_wdog_evt | any_por,
                debug_write: (req.wr && req.addr == OFF_DBG_RESET) | any_por,
                app_wdog:    app_wdog_evt | any_por,
                software:    sw_reset_evt,
                hardware:    hw_reset_r,
                power_on:    any_por};
  assign ev_bits = ev;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cause_r <= CAUSE_RST;
    else if (req.wr && req.addr == OFF_CAUSE)
      cause_r <= (req.wdata[5:0] & cause_r) | ev_bits;
    else
      cause_r <= cause_r | ev_bits;
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_ev  = {(|ev_bits), pin_por_r};
  assign irq_clr = (req.wr && req.addr == OFF_IRQ_CLR) ? req.wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      irq_stat_r <= '0;
      irq_r      <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      irq_r      <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_en_r);
    end
  end

  // ==========================================================================
  // Read port
  // ==========================================================================
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      bus_rdata <= '0;
    else if (req.rd)
    begin
      if (req.addr == OFF_P0_RET)
        bus_rdata <= {16'h0000, port0_retention_bits};
      else if (req.addr == OFF_P1_RET)
        bus_rdata <= {16'h0000, port1_retention_bits};
      else if (req.addr == OFF_PIN_CFG)
        bus_rdata <= {24'h00_0000, pin_cfg_r};
      else if (req.addr == OFF_HOLD_TIME)
        bus_rdata <= {25'h000_0000, hold_time_r};
      else if (req.addr == OFF_BANDGAP)
        bus_rdata <= {21'h00_0000, bandgap_trim_r};
      else if (req.addr == OFF_RF_BIAS)
        bus_rdata <= {24'h00_0000, rf_bias_sel_r};
      else if (req.addr == OFF_CAUSE)
        bus_rdata <= {26'h000_0000, cause_r};
      else if (req.addr == OFF_IRQ_STAT)
        bus_rdata <= {30'h0000_0000, irq_stat_r};
      else if (req.addr == OFF_IRQ_EN)
        bus_rdata <= {30'h0000_0000, irq_en_r};
      else
        bus_rdata <= '0;
    end
    else
      bus_rdata <= '0;
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_ret_set_bits: assert property (@(posedge clock) disable iff (sys_rst)
    (req.wr && req.addr == OFF_P0_SET) |=> ((port0_retention_bits & $past(req.wdata[15:0])) ==
      $past(req.wdata[15:0])))
    else $error("set alias missed a bit");
  a_ret_clr_bits: assert property (@(posedge clock) disable iff (sys_rst)
    (req.wr && req.addr == OFF_P1_CLR) |=> ((port1_retention_bits & $past(req.wdata[15:0])) == 16'h0000))
    else $error("clear alias missed a bit");
  a_ret_keep_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (req.wr && req.addr == OFF_P0_SET && req.wdata[15:0] == 16'h0000) |=> $stable(port0_retention_bits))
    else $error("zero alias write changed bits");
  a_alias_reads_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (req.rd && (req.addr == OFF_P0_SET || req.addr == OFF_P1_CLR)) |=> bus_rdata == 32'h0000_0000)
    else $error("alias read not zero");
  a_pad_frozen: assert property (@(posedge clock) disable iff (sys_rst)
    (!port0_retention_bits[0] && !$past(sys_rst)) |=> port0_ctrl_out[1:0] == $past(port0_ctrl_out[1:0]))
    else $error("frozen pad moved");
  a_sel_disabled: assert property (@(posedge clock) disable iff (sys_rst)
    (pin_cfg_r.select == SEL_DISABLED) |-> (hold_st_r == HOLD_IDLE || !pin_active) ##1 !pin_por_r)
    else $error("pin reset while disabled");
  a_hold_restart: assert property (@(posedge clock) disable iff (sys_rst)
    (hold_st_r == HOLD_COUNT && !pin_active) |=> (step_cnt_r == 7'd0 && unit_cnt_r == 16'd0))
    else $error("hold counter not restarted");
  a_por_sets_flags: assert property (@(posedge clock) disable iff (sys_rst)
    pin_por_r |=> (cause_r[F_POR] && cause_r[F_EWD] && cause_r[F_DBG] && cause_r[F_AWD]))
    else $error("power-on reset flags not set");
  a_sw_flag: assert property (@(posedge clock) disable iff (sys_rst)
    sw_reset_evt |=> cause_r[F_SW])
    else $error("software reset flag not set");
  a_flag_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (req.wr && req.addr == OFF_CAUSE && req.wdata[5:0] == 6'h00 && ev_bits == 6'h00) |=> cause_r == 6'h00)
    else $error("cause flags not cleared");

  c_pin_fire: cover property (@(posedge clock) disable iff (sys_rst) pin_por_r);
  c_hold_abort: cover property (@(posedge clock) disable iff (sys_rst) hold_st_r == HOLD_COUNT && !pin_active);
  c_irq: cover property (@(posedge clock) disable iff (sys_rst) irq_r);

endmodule // prs_reset_ctrl

// [bench/prs_reset_ctrl_tb.sv]
`timescale 1ns/1ps
module prs_reset_ctrl_tb;
  import prs_pkg::*;

  // Short hold unit keeps pin reset runs brief
  localparam int UNIT = 4;

  logic        clock;
  logic        sys_rst;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_rdata;
  logic        fast_rc_tick;
  logic [15:0] port0_pins;
  logic [15:0] port1_pins;
  logic        reset_pad;
  logic        engine_wdog_evt;
  logic        app_wdog_evt;
  logic        sw_reset_evt;
  logic        por_evt;
  logic [31:0] port0_ctrl_in;
  logic [31:0] port1_ctrl_in;
  logic [31:0] port0_ctrl_out;
  logic [31:0] port1_ctrl_out;
  logic [15:0] port0_retention_bits;
  logic [15:0] port1_retention_bits;
  logic        pin_por_r;
  logic        hw_reset_r;
  logic [10:0] bandgap_trim_r;
  logic [7:0]  rf_bias_sel_r;
  logic        irq_r;
  int          errors;
  int          check_count;
  logic [31:0] rv;

  prs_reset_ctrl #(.HOLD_UNIT_CYC(UNIT)) prs_reset_ctrl_inst (
    .clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .fast_rc_tick(fast_rc_tick),
    .port0_pins(port0_pins), .port1_pins(port1_pins), .reset_pad(reset_pad),
    .engine_wdog_evt(engine_wdog_evt), .app_wdog_evt(app_wdog_evt), .sw_reset_evt(sw_reset_evt),
    .por_evt(por_evt), .port0_ctrl_in(port0_ctrl_in), .port1_ctrl_in(port1_ctrl_in),
    .port0_ctrl_out(port0_ctrl_out), .port1_ctrl_out(port1_ctrl_out),
    .port0_retention_bits(port0_retention_bits), .port1_retention_bits(port1_retention_bits),
    .pin_por_r(pin_por_r), .hw_reset_r(hw_reset_r), .bandgap_trim_r(bandgap_trim_r),
    .rf_bias_sel_r(rf_bias_sel_r), .irq_r(irq_r)
  );

  // ==========================================================================
  // Clock and helpers
  // ==========================================================================
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Tick every second cycle so the counter also sees idle cycles
  always @(posedge clock)
    fast_rc_tick <= !sys_rst && !fast_rc_tick;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_wr    <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe edge
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd   <= 1'b0;
    #1 d = bus_rdata;
  endtask

  function automatic logic [31:0] merge(input logic [15:0] m, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] r;
    for (int i = 0; i < 16; i++)
      r[2*i+:2] = m[i] ? b[2*i+:2] : a[2*i+:2];
    return r;
  endfunction

  // ==========================================================================
  // Pin-triggered reset run
  // ==========================================================================
  task automatic pin_test(input logic [5:0] sel, input logic pol, input logic [6:0] hold,
                          input bit fire, input bit glitch);
    int          n;
    int          g;
    int          first;
    int          pulses;
    int          lo;
    logic [31:0] all;
    n = 2 * hold * UNIT;
    g = glitch ? n - 2 : -1;
    first = -1;
    pulses = 0;
    lo = glitch ? g + 1 + n : n;
    all = pol ? 32'hFFFF_FFFF : 32'h0000_0000;
    // Park the selector so the pin change below cannot start an old count
    wr(OFF_PIN_CFG, 32'h0000_003F);
    wr(OFF_HOLD_TIME, {25'h0, hold});
    wr(OFF_CAUSE, 32'h0000_0000);
    @(posedge clock);
    {port1_pins, port0_pins} <= all ^ (32'h0000_0001 << sel);
    wr(OFF_PIN_CFG, {24'h0, pol, 1'b0, sel});
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      #1 if (pin_por_r === 1'b1) pulses++;
    end
    for (int i = 0; i < 2 * n + 24; i++)
    begin
      @(posedge clock);
      {port1_pins, port0_pins} <= (i == g) ? all ^ (32'h0000_0001 << sel) : all;
      #1 if (pin_por_r === 1'b1)
      begin
        pulses++;
        if (first < 0) first = i;
      end
    end
    chk(pulses, fire ? 1 : 0);
    if (fire) chk(first >= lo && first <= lo + 4, 1);
    @(posedge clock);
    {port1_pins, port0_pins} <= ~all;
    cyc(3);
    rd(OFF_CAUSE, rv);
    chk(rv, fire ? 32'h0000_0039 : 32'h0000_0000);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  logic [31:0] ret_off [2] = '{OFF_P0_RET, OFF_P1_RET};
  logic [31:0] set_off [2] = '{OFF_P0_SET, OFF_P1_SET};
  logic [31:0] clr_off [2] = '{OFF_P0_CLR, OFF_P1_CLR};
  logic [5:0]  cause_exp [6] = '{6'h20, 6'h08, 6'h04, 6'h39, 6'h02, 6'h10};

  initial
  begin
    logic [15:0] m;
    logic [15:0] cur;
    logic [31:0] a;
    logic [31:0] b;
    errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    {bus_wr, bus_rd, reset_pad} = '0;
    {engine_wdog_evt, app_wdog_evt, sw_reset_evt, por_evt} = '0;
    bus_addr = '0;
    bus_wdata = '0;
    {port1_pins, port0_pins} = 32'hFFFF_FFFF;
    port0_ctrl_in = '0;
    port1_ctrl_in = '0;
    void'($urandom(32'heb0a));
    cyc(4);
    sys_rst <= 1'b0;

    rd(OFF_P0_RET, rv);    chk(rv, 32'h0000_FFFF);
    rd(OFF_P1_RET, rv);    chk(rv, 32'h0000_FFFF);
    rd(OFF_P0_SET, rv);    chk(rv, 32'h0000_0000);
    rd(OFF_P1_CLR, rv);    chk(rv, 32'h0000_0000);
    rd(OFF_PIN_CFG, rv);   chk(rv, 32'h0000_003F);
    rd(OFF_HOLD_TIME, rv); chk(rv, 32'h0000_0018);
    rd(OFF_CAUSE, rv);     chk(rv, 32'h0000_003F);
    rd(32'h5000_00A0, rv); chk(rv, 32'h0000_0000);
    rd(OFF_RF_BIAS, rv);   chk(rv, 32'h0000_003A);
    rd(OFF_BANDGAP, rv);   chk(rv, 32'h0000_0000);
    wr(OFF_BANDGAP, 32'h0000_07FF);
    wr(OFF_RF_BIAS, 32'h0000_00C5);
    #1 chk(bandgap_trim_r, 32'h0000_07DF);
    chk(rf_bias_sel_r, 32'h0000_00C5);
    wr(OFF_CAUSE, 32'h0000_003C);
    rd(OFF_CAUSE, rv);     chk(rv, 32'h0000_003C);
    $display("test reset values done");

    for (int p = 0; p < 2; p++)
      for (int it = 0; it < 4; it++)
      begin
        m = (it == 0) ? 16'h0000 : 16'($urandom);
        a = $urandom;
        b = $urandom;
        wr(ret_off[p], 32'h0000_FFFF);
        if (p == 1) port1_ctrl_in <= a; else port0_ctrl_in <= a;
        cyc(3);
        wr(ret_off[p], {16'hFFFF, m});
        if (p == 1) port1_ctrl_in <= b; else port0_ctrl_in <= b;
        cyc(3);
        #1 chk(p == 1 ? port1_ctrl_out : port0_ctrl_out, merge(m, a, b));
        cur = m;
        a = (it == 1) ? 32'h0000_0000 : $urandom;
        wr(set_off[p], a);
        cur = cur | a[15:0];
        b = $urandom;
        wr(clr_off[p], b);
        cur = cur & ~b[15:0];
        #1 chk(p == 1 ? port1_retention_bits : port0_retention_bits, cur);
        rd(ret_off[p], rv); chk(rv, {16'h0, cur});
        rd(set_off[p], rv); chk(rv, 32'h0000_0000);
        rd(clr_off[p], rv); chk(rv, 32'h0000_0000);
      end
    $display("test retention done");

    for (int k = 0; k < 6; k++)
    begin
      wr(OFF_CAUSE, 32'h0000_0000);
      rd(OFF_CAUSE, rv); chk(rv, 32'h0000_0000);
      @(posedge clock);
      case (k)
        0: engine_wdog_evt <= 1'b1;
        1: app_wdog_evt <= 1'b1;
        2: sw_reset_evt <= 1'b1;
        3: por_evt <= 1'b1;
        4: reset_pad <= 1'b1;
        default: ;
      endcase
      @(posedge clock);
      {engine_wdog_evt, app_wdog_evt, sw_reset_evt, por_evt, reset_pad} <= '0;
      #1 chk(hw_reset_r, k == 4);
      if (k == 5) wr(OFF_DBG_RESET, $urandom);
      cyc(2);
      rd(OFF_CAUSE, rv); chk(rv, {26'h0, cause_exp[k]});
      rd(OFF_CAUSE, rv); chk(rv, {26'h0, cause_exp[k]});
    end
    $display("test cause flags done");

    wr(OFF_IRQ_CLR, 32'h0000_0003);
    wr(OFF_IRQ_EN, 32'h0000_0000);
    pin_test(6'h05, 1'b0, 7'd2, 1, 0);
    pin_test(6'h1A, 1'b1, 7'd2, 1, 0);
    pin_test(6'h0F, 1'b1, 7'd0, 1, 0);
    pin_test(6'h10, 1'b0, 7'd3, 1, 1);
    pin_test(6'h25, 1'b1, 7'd1, 0, 0);
    pin_test(6'h3F, 1'b0, 7'd1, 0, 0);
    for (int i = 0; i < 4; i++)
      pin_test(6'($urandom_range(0, 31)), 1'($urandom), 7'($urandom_range(1, 3)), 1, 0);
    $display("test pin reset done");

    // Masked events must leave the line low
    chk(irq_r, 1'b0);
    rd(OFF_IRQ_STAT, rv); chk(rv, 32'h0000_0003);
    wr(OFF_IRQ_EN, 32'h0000_0001);
    cyc(2);
    #1 chk(irq_r, 1'b1);
    wr(OFF_IRQ_CLR, 32'h0000_0001);
    cyc(2);
    #1 chk(irq_r, 1'b0);
    rd(OFF_IRQ_STAT, rv); chk(rv, 32'h0000_0002);
    rd(OFF_IRQ_CLR, rv);  chk(rv, 32'h0000_0000);
    $display("test interrupt done");
    wrap_up();
  end

  initial
  begin
    repeat (60000) @(posedge clock);
    errors++;
    wrap_up();
  end

endmodule // prs_reset_ctrl_tb
